// ==== common/cstf_map.svh ====
// Register map, field positions and counts for the CAN status block.
// Assumes a byte-addressed 8-bit register port with 32-bit words.
// Notes on behaviour
// - A CAN bus error sets the bus-error flag.
// - A system-bus fault, such as an illegal address, sets the system-error flag.
// - System-error flag ignores writes; clears only when module is switched off then on.
// - A receive buffer overflow sets the buffer-overflow flag.
// - Mode-change flag sets when mode status changes to match the requested mode.
// - Sixteen read-only per-FIFO overflow flags sit in bits 15 to 0.
// - With capture enabled the 16-bit timer advances once per prescaler period.
// - With capture disabled the timer holds its value.
// - Prescale zero advances every clock; all ones every 65,535 clocks.
// - Any timer register write resets the prescaler count and also loads the setting.
// - Filter FIFO select 0 to 15 routes to that FIFO; 16 to 31 reserved.
// - Each filter has an enable and a 2-bit mask select choosing mask 0 to 3.
// - Filter control bits other than the enable change only while that filter is disabled.
// - FIFO direction bit 7: one is transmit, zero is receive.
// - Aborted bit: one aborted, zero success; updates on completion, abort, FIFO reset.
// - Lost-arbitration and transmit-error bits clear on control read or FIFO reset.
// - Send request starts sending, clears when done; software clear asks abort.
// - With auto-remote enabled a received remote request sets send request.
// - Priority 0 lowest to 3 highest; some bits change only in mode 100.
// - User address reads head for transmit FIFO, tail for receive FIFO.
`ifndef CSTF_MAP_SVH
`define CSTF_MAP_SVH
`define CSTF_OFS_INT    8'h00
`define CSTF_OFS_OVF    8'h04
`define CSTF_OFS_TMR    8'h08
`define CSTF_OFS_FLT    8'h0c
`define CSTF_OFS_CTL    8'h10
`define CSTF_OFS_FCTL   8'h40
`define CSTF_OFS_FUA    8'h80
`define CSTF_NFIFO      16
`define CSTF_NFLT       4
`define CSTF_INT_WAKE   14
`define CSTF_INT_BERR   13
`define CSTF_INT_SERR   12
`define CSTF_INT_RBOV   11
`define CSTF_INT_MOD    3
`define CSTF_INT_TMR    2
`define CSTF_INT_RB     1
`define CSTF_INT_TB     0
`define CSTF_CTL_ON     15
`define CSTF_CTL_CAP    20
`define CSTF_CTL_OPLO   21
`define CSTF_CTL_RQLO   24
`define CSTF_FC_DIR     7
`define CSTF_FC_ABT     6
`define CSTF_FC_ARB     5
`define CSTF_FC_ERR     4
`define CSTF_FC_REQ     3
`define CSTF_FC_RTR     2
`define CSTF_MODE_CFG   3'h4
`define CSTF_FSEL_MAX   5'h0f
`endif

// ==== common/cstf_pkg.sv ====
// Types shared by the CAN status block.
// Assumes the map header is included by every user.
package cstf_pkg;
  typedef logic [2:0]  cstf_mode_t;
  typedef logic [15:0] cstf_word16_t;
endpackage : cstf_pkg

// ==== hw/cstf_timer.sv ====
// Time-stamp timer with prescaler.
// Assumes load and capture come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "cstf_map.svh"
module cstf_timer (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst,
  // Control
  input  wire logic           capture_en,
  input  wire cstf_pkg::cstf_word16_t prescale,
  input  wire logic           load,
  input  wire cstf_pkg::cstf_word16_t load_val,
  // State
  output logic [15:0]         count,
  output logic                wrap
);
  import cstf_pkg::*;
  logic [15:0] pre_cnt;
  logic        tick;
  // Compare with >= so a smaller prescale mid-period cannot stall the count
  assign tick = capture_en && ((prescale == 16'h0) || (pre_cnt >= prescale - 16'h1));
  assign wrap = tick && !load && (count == 16'hffff);
  always_ff @(posedge clk) begin
    if (rst || load || tick) begin
      pre_cnt <= 16'h0;
    end else if (capture_en) begin
      pre_cnt <= pre_cnt + 16'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= 16'h0;
    end else if (load) begin
      count <= load_val;
    end else if (tick) begin
      count <= count + 16'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_hold;
    !capture_en && !load |=> $stable(count);
  endproperty
  a_hold: assert property (p_hold) else $error("timer moved while paused");
  property p_wrap;
    wrap |=> count == 16'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("timer did not wrap to zero");
  property p_every;
    capture_en && !load && prescale == 16'h0 |=> count == $past(count) + 16'h1;
  endproperty
  a_every: assert property (p_every) else $error("zero prescale missed a step");
endmodule : cstf_timer
`default_nettype wire

// ==== hw/cstf_fifo_ctl.sv ====
// Control and status bits of one message FIFO.
// Assumes all event inputs are one-cycle pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "cstf_map.svh"
module cstf_fifo_ctl (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Register access
  input  wire logic       wr,
  input  wire logic       rd,
  input  wire logic [7:0] wdata,
  input  wire logic       cfg_mode,
  // Events from the message engine
  input  wire logic       all_sent,
  input  wire logic       msg_done,
  input  wire logic       msg_abort,
  input  wire logic       lost_arb_ev,
  input  wire logic       bus_err_ev,
  input  wire logic       rtr_rx,
  input  wire logic       fifo_reset,
  // State
  output logic [7:0]      ctl,
  output logic            abort_req
);
  import cstf_pkg::*;
  logic dir, aborted, lost, transmit_bus_error, send, rtr_en;
  logic [1:0] prio;
  assign ctl = {dir, aborted, lost, transmit_bus_error, send, rtr_en, prio};
  assign abort_req = wr && dir && send && !wdata[`CSTF_FC_REQ];
  always_ff @(posedge clk) begin
    if (rst) begin
      dir <= 1'b0;
    end else if (wr && cfg_mode) begin
      dir <= wdata[`CSTF_FC_DIR];
    end
  end
  always_ff @(posedge clk) begin
    if (rst || fifo_reset || msg_done) begin
      aborted <= 1'b0;
    end else if (msg_abort) begin
      aborted <= 1'b1;
    end
  end
  // A fresh event beats a clearing read in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      lost  <= 1'b0;
      transmit_bus_error <= 1'b0;
    end else begin
      lost  <= lost_arb_ev || (lost && !rd && !fifo_reset);
      transmit_bus_error <= bus_err_ev || (transmit_bus_error && !rd && !fifo_reset);
    end
  end
  always_ff @(posedge clk) begin
    if (rst || fifo_reset || !dir) begin
      send <= 1'b0;
    end else if (rtr_rx && rtr_en) begin
      send <= 1'b1;
    end else if (all_sent) begin
      send <= 1'b0;
    end else if (wr) begin
      send <= wdata[`CSTF_FC_REQ];
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      rtr_en <= 1'b0;
      prio   <= 2'h0;
    end else if (wr) begin
      rtr_en <= wdata[`CSTF_FC_RTR];
      prio   <= wdata[1:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_sw_abort;
    wr && dir && send && !wdata[`CSTF_FC_REQ] && !(rtr_rx && rtr_en);
  endsequence
  property p_abort;
    s_sw_abort |-> abort_req ##1 !send;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not clear send");
  property p_rtr;
    dir && rtr_en && rtr_rx && !fifo_reset |=> send;
  endproperty
  a_rtr: assert property (p_rtr) else $error("remote request not honoured");
  property p_rdclr;
    rd && !lost_arb_ev && !bus_err_ev |=> !lost && !transmit_bus_error;
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("read did not clear status");
endmodule : cstf_fifo_ctl
`default_nettype wire

// ==== hw/cstf_top.sv ====
// Top of the CAN status, time-stamp, filter routing and FIFO control block.
// Assumes event inputs are same-clock pulses from the rest of the controller.
`timescale 1ns/1ps
`default_nettype none
`include "cstf_map.svh"
module cstf_top (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Register port
  input  wire logic [7:0]         addr,
  input  wire logic [31:0]        wdata,
  input  wire logic               wr_en,
  input  wire logic               rd_en,
  output logic [31:0]             rdata,
  // Controller events
  input  wire logic               wake_event,
  input  wire logic               bus_error_event,
  input  wire logic               sys_error_event,
  input  wire logic               rx_pending,
  input  wire logic               tx_pending,
  input  wire cstf_pkg::cstf_mode_t operating_mode_status,
  // Per-FIFO events
  input  wire logic [15:0]        fifo_overflow_event,
  input  wire logic [15:0]        fifo_all_sent,
  input  wire logic [15:0]        fifo_msg_done,
  input  wire logic [15:0]        fifo_msg_abort,
  input  wire logic [15:0]        fifo_lost_arb,
  input  wire logic [15:0]        fifo_bus_err,
  input  wire logic [15:0]        fifo_rtr_rx,
  input  wire logic [15:0]        fifo_reset,
  input  wire logic [15:0][31:0]  fifo_head_addr,
  input  wire logic [15:0][31:0]  fifo_tail_addr,
  // Control outputs
  output logic                    module_on,
  output logic                    timestamp_capture_enable,
  output cstf_pkg::cstf_mode_t    requested_operating_mode,
  output logic [15:0]             timestamp_count,
  output logic [3:0]              filter_enable,
  output logic [3:0][1:0]         filter_mask_select,
  output logic [3:0][4:0]         filter_fifo_select,
  output logic [15:0]             fifo_direction,
  output logic [15:0]             send_request,
  output logic [15:0]             abort_request,
  output logic [15:0][1:0]        transmit_priority
);
  import cstf_pkg::*;

  // ****************************************
  // Address decode
  // ****************************************
  // Returns {hit, index} for a 16-slot word window
  function automatic logic [4:0] slot(input logic [7:0] a, input logic [7:0] base);
    slot = {(a[7:6] == base[7:6]) && (a[1:0] == 2'h0), a[5:2]};
  endfunction

  logic [4:0]  fctl_slot, fua_slot;
  logic        addr_hit;
  logic [31:0] next_rdata;
  assign fctl_slot = slot(addr, `CSTF_OFS_FCTL);
  assign fua_slot  = slot(addr, `CSTF_OFS_FUA);

  // ****************************************
  // Control and filter registers
  // ****************************************
  logic        prev_on;
  cstf_mode_t  prev_mode;
  logic [31:0] flt;
  cstf_word16_t prescale;
  logic        tmr_wr, tmr_wrap;

  always_ff @(posedge clk) begin
    if (rst) begin
      module_on                <= 1'b0;
      timestamp_capture_enable <= 1'b0;
      requested_operating_mode <= `CSTF_MODE_CFG;
    end else if (wr_en && addr == `CSTF_OFS_CTL) begin
      module_on                <= wdata[`CSTF_CTL_ON];
      timestamp_capture_enable <= wdata[`CSTF_CTL_CAP];
      requested_operating_mode <= wdata[`CSTF_CTL_RQLO +: 3];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_on   <= 1'b0;
      prev_mode <= `CSTF_MODE_CFG;
    end else begin
      prev_on   <= module_on;
      prev_mode <= operating_mode_status;
    end
  end

  // Each filter owns one byte: enable, mask select, FIFO select
  genvar f;
  generate
    for (f = 0; f < `CSTF_NFLT; f++) begin : g_flt
      always_ff @(posedge clk) begin
        if (rst) begin
          flt[f*8 +: 8] <= 8'h0;
        end else if (wr_en && addr == `CSTF_OFS_FLT) begin
          flt[f*8+7] <= wdata[f*8+7];
          // Disabling stays possible so a locked filter can be reopened
          if (!flt[f*8+7]) begin
            flt[f*8 +: 7] <= wdata[f*8 +: 7];
          end
        end
      end
      assign filter_enable[f]      = flt[f*8+7];
      assign filter_mask_select[f] = flt[f*8+5 +: 2];
      assign filter_fifo_select[f] = flt[f*8 +: 5];
    end
  endgenerate

  // ****************************************
  // Time-stamp timer
  // ****************************************
  assign tmr_wr = wr_en && addr == `CSTF_OFS_TMR;

  always_ff @(posedge clk) begin
    if (rst) begin
      prescale <= 16'h0;
    end else if (tmr_wr) begin
      prescale <= wdata[15:0];
    end
  end

  cstf_timer u_timer (
    .clk        (clk),
    .rst        (rst),
    .capture_en (timestamp_capture_enable),
    .prescale   (prescale),
    .load       (tmr_wr),
    .load_val   (wdata[31:16]),
    .count      (timestamp_count),
    .wrap       (tmr_wrap)
  );

  // ****************************************
  // Interrupt flags
  // ****************************************
  logic        wake_flag, berr_flag, serr_flag, rbov_flag, mode_flag, tmr_flag;
  logic        int_wr, bad_access, mode_hit, on_rise;
  logic [15:0] fifo_ovf;

  assign int_wr     = wr_en && addr == `CSTF_OFS_INT;
  assign bad_access = (wr_en || rd_en) && !addr_hit;
  assign mode_hit   = operating_mode_status != prev_mode
                      && operating_mode_status == requested_operating_mode;
  assign on_rise    = module_on && !prev_on;

  // A written zero clears; an event in the same cycle still wins
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_flag <= 1'b0;
      berr_flag <= 1'b0;
      rbov_flag <= 1'b0;
      mode_flag <= 1'b0;
      tmr_flag  <= 1'b0;
    end else begin
      wake_flag <= wake_event || (wake_flag && !(int_wr && !wdata[`CSTF_INT_WAKE]));
      berr_flag <= bus_error_event
                   || (berr_flag && !(int_wr && !wdata[`CSTF_INT_BERR]));
      rbov_flag <= |fifo_overflow_event
                   || (rbov_flag && !(int_wr && !wdata[`CSTF_INT_RBOV]));
      mode_flag <= mode_hit || (mode_flag && !(int_wr && !wdata[`CSTF_INT_MOD]));
      tmr_flag  <= tmr_wrap || (tmr_flag && !(int_wr && !wdata[`CSTF_INT_TMR]));
    end
  end

  // Only an off-then-on cycle of the module clears this one
  always_ff @(posedge clk) begin
    if (rst) begin
      serr_flag <= 1'b0;
    end else begin
      serr_flag <= sys_error_event || bad_access || (serr_flag && !on_rise);
    end
  end

  genvar q;
  generate
    for (q = 0; q < `CSTF_NFIFO; q++) begin : g_ovf
      always_ff @(posedge clk) begin
        if (rst) begin
          fifo_ovf[q] <= 1'b0;
        end else begin
          fifo_ovf[q] <= fifo_overflow_event[q] || (fifo_ovf[q] && !fifo_reset[q]);
        end
      end
    end
  endgenerate

  // ****************************************
  // FIFO control
  // ****************************************
  logic [15:0][7:0] fctl;
  logic             cfg_mode;
  assign cfg_mode = operating_mode_status == `CSTF_MODE_CFG;

  genvar n;
  generate
    for (n = 0; n < `CSTF_NFIFO; n++) begin : g_fifo
      cstf_fifo_ctl u_fifo (
        .clk         (clk),
        .rst         (rst),
        .wr          (wr_en && fctl_slot == {1'b1, 4'(n)}),
        .rd          (rd_en && fctl_slot == {1'b1, 4'(n)}),
        .wdata       (wdata[7:0]),
        .cfg_mode    (cfg_mode),
        .all_sent    (fifo_all_sent[n]),
        .msg_done    (fifo_msg_done[n]),
        .msg_abort   (fifo_msg_abort[n]),
        .lost_arb_ev (fifo_lost_arb[n]),
        .bus_err_ev  (fifo_bus_err[n]),
        .rtr_rx      (fifo_rtr_rx[n]),
        .fifo_reset  (fifo_reset[n]),
        .ctl         (fctl[n]),
        .abort_req   (abort_request[n])
      );
      assign fifo_direction[n]    = fctl[n][`CSTF_FC_DIR];
      assign send_request[n]      = fctl[n][`CSTF_FC_REQ];
      assign transmit_priority[n] = fctl[n][1:0];
    end
  endgenerate

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    next_rdata = 32'h0;
    addr_hit   = 1'b1;
    case (addr)
      `CSTF_OFS_INT: begin
        next_rdata[`CSTF_INT_WAKE] = wake_flag;
        next_rdata[`CSTF_INT_BERR] = berr_flag;
        next_rdata[`CSTF_INT_SERR] = serr_flag;
        next_rdata[`CSTF_INT_RBOV] = rbov_flag;
        next_rdata[`CSTF_INT_MOD]  = mode_flag;
        next_rdata[`CSTF_INT_TMR]  = tmr_flag;
        next_rdata[`CSTF_INT_RB]   = rx_pending;
        next_rdata[`CSTF_INT_TB]   = tx_pending;
      end
      `CSTF_OFS_OVF: next_rdata[15:0] = fifo_ovf;
      `CSTF_OFS_TMR: next_rdata = {timestamp_count, prescale};
      `CSTF_OFS_FLT: next_rdata = flt;
      `CSTF_OFS_CTL: begin
        next_rdata[`CSTF_CTL_ON]        = module_on;
        next_rdata[`CSTF_CTL_CAP]       = timestamp_capture_enable;
        next_rdata[`CSTF_CTL_OPLO +: 3] = operating_mode_status;
        next_rdata[`CSTF_CTL_RQLO +: 3] = requested_operating_mode;
      end
      default: begin
        if (fctl_slot[4]) begin
          next_rdata[7:0] = fctl[fctl_slot[3:0]];
        end else if (fua_slot[4]) begin
          // Low two bits forced low to keep messages word-aligned
          next_rdata = (fctl[fua_slot[3:0]][`CSTF_FC_DIR] ? fifo_head_addr[fua_slot[3:0]]
                        : fifo_tail_addr[fua_slot[3:0]]) & 32'hffff_fffc;
        end else begin
          addr_hit = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst || !rd_en) begin
      rdata <= 32'h0;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_off_on;
    !module_on ##1 module_on;
  endsequence
  property p_serr_keep;
    serr_flag && !(module_on && !$past(module_on)) |=> serr_flag;
  endproperty
  a_serr_keep: assert property (p_serr_keep) else $error("system error cleared early");
  property p_serr_clear;
    s_off_on ##0 !sys_error_event && !bad_access |=> !serr_flag;
  endproperty
  a_serr_clear: assert property (p_serr_clear) else $error("system error not cleared");
  property p_bad;
    bad_access |=> serr_flag;
  endproperty
  a_bad: assert property (p_bad) else $error("illegal address not flagged");
  property p_mode;
    operating_mode_status != $past(operating_mode_status)
      && operating_mode_status == requested_operating_mode |=> mode_flag;
  endproperty
  a_mode: assert property (p_mode) else $error("mode change not flagged");
  property p_berr_win;
    bus_error_event && int_wr |=> berr_flag;
  endproperty
  a_berr_win: assert property (p_berr_win) else $error("bus error lost to clear");
  property p_wake_clr;
    int_wr && !wdata[`CSTF_INT_WAKE] && !wake_event |=> !wake_flag;
  endproperty
  a_wake_clr: assert property (p_wake_clr) else $error("wake flag not cleared");
  property p_tmrflag;
    tmr_wrap |=> tmr_flag && timestamp_count == 16'h0;
  endproperty
  a_tmrflag: assert property (p_tmrflag) else $error("overflow flag missing");
  property p_flt_lock;
    flt[7] |=> flt[6:0] == $past(flt[6:0]);
  endproperty
  a_flt_lock: assert property (p_flt_lock) else $error("enabled filter changed");
  property p_rd_late;
    rd_en && addr == `CSTF_OFS_OVF ##1 !rd_en |-> rdata[15:0] == $past(fifo_ovf);
  endproperty
  a_rd_late: assert property (p_rd_late) else $error("overflow read wrong");
  property p_rx_idle;
    !fifo_direction[0] |=> !send_request[0];
  endproperty
  a_rx_idle: assert property (p_rx_idle) else $error("receive FIFO sending");
endmodule : cstf_top
`default_nettype wire

// ==== test/cstf_node_model.sv ====
// Far-side model: wake and bus-error pulses, and a mode status that lags the request.
// Assumes the block's clock; go is a one-cycle pulse from the bench.
`timescale 1ns/1ps
`default_nettype none
module cstf_node_model (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Stimulus and request
  input  wire logic                 go,
  input  wire cstf_pkg::cstf_mode_t req_mode,
  // Events to the block
  output logic                      wake_event,
  output logic                      bus_error_event,
  output cstf_pkg::cstf_mode_t      mode_status
);
  import cstf_pkg::*;
  // ****
  // Mode follower
  // ****
  cstf_mode_t lag;
  // Mode change lands late so the flag cannot ride on the request write
  always_ff @(posedge clk) begin
    if (rst) begin
      lag <= 3'h4;
      mode_status <= 3'h4;
    end else begin
      lag <= req_mode;
      mode_status <= lag;
    end
  end
  always_ff @(posedge clk) begin
    wake_event <= go & ~rst;
    bus_error_event <= go & ~rst;
  end
endmodule : cstf_node_model
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench: registers, events, timer, filters and FIFO control.
// Assumes the far-side model drives wake, bus error and mode status.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cstf_pkg::*;
  // ****
  // Harness
  // ****
  logic clk, rst, wr_en, rd_en, go, sev, tx_pending, rx_pending, wake, berr, on, cap;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, r, v;
  logic [7:0][15:0] fe;
  logic [15:0][31:0] ha, ta;
  cstf_mode_t ms, rqm;
  logic [15:0] tsc, fdir, sreq, abr, abs;
  logic [3:0] fen;
  logic [3:0][1:0] fmsk;
  logic [3:0][4:0] fsel;
  logic [15:0][1:0] prio;
  int fails, tests_run, n, m, p, c;
  cstf_node_model node_u (.clk(clk), .rst(rst), .go(go), .req_mode(rqm),
    .wake_event(wake), .bus_error_event(berr), .mode_status(ms));
  cstf_top dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .wake_event(wake), .bus_error_event(berr),
    .sys_error_event(sev), .rx_pending(rx_pending), .tx_pending(tx_pending),
    .operating_mode_status(ms), .fifo_overflow_event(fe[0]), .fifo_all_sent(fe[1]),
    .fifo_msg_done(fe[2]), .fifo_msg_abort(fe[3]), .fifo_lost_arb(fe[4]),
    .fifo_bus_err(fe[5]), .fifo_rtr_rx(fe[6]), .fifo_reset(fe[7]),
    .fifo_head_addr(ha), .fifo_tail_addr(ta), .module_on(on),
    .timestamp_capture_enable(cap), .requested_operating_mode(rqm),
    .timestamp_count(tsc), .filter_enable(fen), .filter_mask_select(fmsk),
    .filter_fifo_select(fsel), .fifo_direction(fdir), .send_request(sreq),
    .abort_request(abr), .transmit_priority(prio));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Abort pulses last one cycle, so keep a sticky copy for the checks
  always_ff @(posedge clk) begin
    abs <= rst ? 16'h0 : (abs | abr);
  end
  function automatic logic [31:0] cw(logic o, logic t, cstf_mode_t md);
    return {5'h0, md, 3'h0, t, 4'h0, o, 15'h0};
  endfunction : cw
  task automatic give_verdict;
    if (fails == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    #1;
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] mk);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 r = rdata & mk;
  endtask : rd
  task automatic fev(int k, int i);
    @(posedge clk);
    fe[k][i] <= 1'b1;
    @(posedge clk);
    fe <= '0;
    #1;
  endtask : fev
  // Bounded wait for the next timer step, counting cycles
  task automatic wchg;
    logic [15:0] o;
    o = tsc;
    c = 0;
    while (tsc === o) begin
      @(posedge clk);
      #1 c++;
      if (c > 300) begin
        fails++;
        give_verdict();
      end
    end
  endtask : wchg
  // ****
  // Scenarios
  // ****
  initial begin
    {rst, wr_en, rd_en, go, sev, tx_pending, rx_pending} = 7'h40;
    addr = 8'h00;
    wdata = 32'h0;
    fe = '0;
    fails = 0;
    tests_run = 0;
    void'($urandom(95));
    for (int i = 0; i < 16; i++) begin
      ha[i] = $urandom;
      ta[i] = $urandom;
    end
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(8'h04, 32'hffffffff);
    chk("ovf_reset", 32'h0, r);
    rd(8'h10, 32'hffffffff);
    chk("ctl_reset", cw(0, 0, 3'h4) | 32'h00800000, r);
    @(posedge clk);
    tx_pending <= 1'b1;
    rd(8'h00, 32'h3);
    chk("pending", 32'h1, r);
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    rd(8'h00, 32'h6000);
    chk("wake_berr", 32'h6000, r);
    rd(8'hfc, 32'hffffffff);
    chk("unmapped", 32'h0, r);
    wr(8'h00, 32'h0);
    rd(8'h00, 32'h7000);
    chk("int_clear", 32'h1000, r);
    wr(8'h10, cw(1, 0, 3'h4));
    @(posedge clk);
    sev <= 1'b1;
    @(posedge clk);
    sev <= 1'b0;
    rd(8'h00, 32'h1000);
    chk("sys_err", 32'h1000, r);
    wr(8'h10, cw(0, 0, 3'h4));
    wr(8'h10, cw(1, 0, 3'h4));
    rd(8'h00, 32'h1000);
    chk("serr_off_on", 32'h0, r);
    n = $urandom % 16;
    m = (n + 1) % 16;
    fev(0, n);
    rd(8'h04, 32'hffffffff);
    chk("fifo_ovf", 32'h1 << n, r);
    rd(8'h00, 32'h800);
    chk("rx_ovf", 32'h800, r);
    p = $urandom % 6;
    wr(8'h08, p);
    wr(8'h10, cw(1, 1, 3'h4));
    chk("on_cap", 32'h3, {on, cap});
    wchg();
    wchg();
    chk("period", (p == 0) ? 1 : p, c);
    wr(8'h10, cw(1, 0, 3'h4));
    v = tsc;
    repeat (20) @(posedge clk);
    chk("paused", v, tsc);
    wr(8'h08, 32'hfffe0000);
    wr(8'h10, cw(1, 1, 3'h4));
    wchg();
    wchg();
    chk("wrap", 32'h0, tsc);
    wr(8'h10, cw(1, 0, 3'h4));
    rd(8'h00, 32'h4);
    chk("tmr_ovf", 32'h4, r);
    v = $urandom & 32'h7f7f7f7f;
    wr(8'h0c, v);
    rd(8'h0c, 32'hffffffff);
    chk("filters", v, r);
    chk("fsel0", v[4:0], fsel[0]);
    wr(8'h0c, v | 32'h80808080);
    wr(8'h0c, (~v & 32'h7f7f7f7f) | 32'h80808080);
    rd(8'h0c, 32'hffffffff);
    chk("flt_lock", v | 32'h80808080, r);
    chk("en_mask", {4'hf, v[6:5]}, {fen, fmsk[0]});
    // Direction must be set first: send request is refused while receive
    wr(8'h40 + 4 * n, 32'h80);
    wr(8'h40 + 4 * n, 32'h8f);
    chk("fifo_cfg", 32'hf, {fdir[n], sreq[n], prio[n]});
    fev(1, n);
    chk("sent", 32'h0, sreq[n]);
    fev(6, n);
    chk("auto_rtr", 32'h1, sreq[n]);
    wr(8'h40 + 4 * n, 32'h84);
    chk("abort", 32'h0, sreq[n]);
    chk("abort_pulse", 32'h1 << n, abs);
    fev(4, n);
    fev(5, n);
    rd(8'h40 + 4 * n, 32'h30);
    chk("arb_err", 32'h30, r);
    rd(8'h40 + 4 * n, 32'h30);
    chk("rd_clear", 32'h0, r);
    fev(3, n);
    rd(8'h40 + 4 * n, 32'h40);
    chk("aborted", 32'h40, r);
    fev(2, n);
    rd(8'h40 + 4 * n, 32'h40);
    chk("done", 32'h0, r);
    rd(8'h80 + 4 * n, 32'hffffffff);
    chk("head", ha[n] & 32'hfffffffc, r);
    wr(8'h10, cw(1, 0, 3'h0));
    repeat (6) @(posedge clk);
    rd(8'h00, 32'h8);
    chk("mode_flag", 32'h8, r);
    wr(8'h40 + 4 * n, 32'h03);
    chk("dir_lock", 32'h1, fdir[n]);
    wr(8'h40 + 4 * m, 32'h08);
    chk("rx_req", 32'h0, sreq[m]);
    rd(8'h80 + 4 * m, 32'hffffffff);
    chk("tail", ta[m] & 32'hfffffffc, r);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
